// ===== hw/meta_pkg.sv
// Package for the extended-type access block: type codes, widths, limits.
// Assumes it is compiled before every other design file of the block.
package meta_pkg;

    // ------------------------------------------------------------------
    // Address layout
    // ------------------------------------------------------------------
    localparam int ADDR_W      = 16;
    localparam int INDEX_W     = 14;
    localparam int TYPE_HI_BIT = 15;
    localparam int TYPE_LO_BIT = 14;
    localparam int COUNT_W     = 16;
    localparam int WORD_W      = 16;
    localparam int PARAM_W     = 32;

    // ------------------------------------------------------------------
    // Type selector codes
    // ------------------------------------------------------------------
    localparam logic [1:0] TYPE_INT16   = 2'h0;
    localparam logic [1:0] TYPE_INT32   = 2'h1;
    localparam logic [1:0] TYPE_FLOAT32 = 2'h2;
    localparam logic [1:0] TYPE_RSVD    = 2'h3;

    // ------------------------------------------------------------------
    // Exception and function code handling
    // ------------------------------------------------------------------
    localparam logic [7:0] EXC_ADDR_RANGE = 8'h02;
    localparam logic [7:0] FC_EXC_FLAG    = 8'h80;
    localparam logic [7:0] FC_READ_MULTI  = 8'h03;
    localparam logic [7:0] FC_WRITE_MULTI = 8'h10;
    localparam logic [7:0] FC_RW_MULTI    = 8'h17;

    // ------------------------------------------------------------------
    // Buffering
    // ------------------------------------------------------------------
    localparam int FIFO_DEPTH = 32;

    typedef enum logic [1:0] {
        META_OP_READ,
        META_OP_WRITE
    } meta_op_e;

endpackage

// ===== hw/meta_word_if.sv
// Word stream carrier between the access engine and its output FIFO.
// Assumes a single clock; valid and ready follow the usual handshake.
`timescale 1ns/100ps
interface meta_word_if #(parameter int W = 16);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;

    modport src (output valid, output data, input ready);
    modport dst (input valid, input data, output ready);
endinterface

// ===== hw/meta_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock; DEPTH is a power of two.
`timescale 1ns/100ps
module meta_fifo
    import meta_pkg::*;
#(
    parameter int W     = 16,
    parameter int DEPTH = 32
) (
    input  wire logic core_clk,
    input  wire logic arst_n,
    meta_word_if.dst  wr,
    meta_word_if.src  rd
);

    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW:0] wp;
        logic [AW:0] rp;
    } meta_fifo_s;

    meta_fifo_s   st_ff;
    meta_fifo_s   nxt_st;
    logic [W-1:0] mem [DEPTH];
    logic         full;
    logic         empty;

    // ------------------------------------------------------------------
    // Flags and handshake
    // ------------------------------------------------------------------
    // Full when pointers differ only in the wrap bit.
    assign full     = (st_ff.wp[AW] != st_ff.rp[AW]) && (st_ff.wp[AW-1:0] == st_ff.rp[AW-1:0]);
    assign empty    = (st_ff.wp == st_ff.rp);
    assign wr.ready = !full;
    assign rd.valid = !empty;
    assign rd.data  = mem[st_ff.rp[AW-1:0]];

    // Pointer advance on accepted transfers.
    always_comb begin
        nxt_st = st_ff;
        if (wr.valid && !full) begin
            nxt_st.wp = st_ff.wp + 1'b1;
        end
        if (rd.ready && !empty) begin
            nxt_st.rp = st_ff.rp + 1'b1;
        end
    end

    // Storage has no reset; only pointers need a defined value.
    always_ff @(posedge core_clk) begin
        if (wr.valid && !full) begin
            mem[st_ff.wp[AW-1:0]] <= wr.data;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

endmodule // meta_fifo

// ===== hw/meta_access.sv
// Extended data type access engine for a multiple-register slave.
// Assumes framing/CRC are outside; a request arrives as one strobe with
// start address and count, the parameter store answers combinationally
// in the same cycle it is addressed, and reply words drain via a FIFO.
//
// Limitations: the write half of a combined read/write request is not
// handled here, so that function code is served as a plain read. The
// store's read strobe trails the cycle in which its data was sampled,
// which keeps every store-facing output a register at the cost of one
// cycle of lag. Refusals never touch the store, so a rejected block
// leaves every parameter as it was.
`timescale 1ns/100ps
module meta_access
    import meta_pkg::*;
#(
    parameter bit FLOAT_OK = 1'b1
) (
    input  wire logic                 core_clk,
    input  wire logic                 arst_n,
    // Request side.
    input  wire logic                 req_valid,
    input  wire logic [7:0]           req_func,
    input  wire logic [ADDR_W-1:0]    req_addr,
    input  wire logic [COUNT_W-1:0]   req_count,
    output logic                      req_ready,
    // Write data words from the master, one per register.
    input  wire logic                 wdata_valid,
    input  wire logic [WORD_W-1:0]    wdata,
    output logic                      wdata_ready,
    // Parameter store.
    output logic                      ps_rd_ff,
    output logic                      ps_wr_ff,
    output logic [INDEX_W-1:0]        ps_index_ff,
    output logic [PARAM_W-1:0]        ps_wdata_ff,
    output logic                      ps_float_ff,
    input  wire logic [PARAM_W-1:0]   ps_rdata,
    input  wire logic                 ps_is32,
    // Reply words.
    output logic                      rsp_valid,
    output logic [WORD_W-1:0]         rsp_data,
    input  wire logic                 rsp_ready,
    // Completion.
    output logic                      done_ff,
    output logic                      exc_ff,
    output logic [7:0]                exc_func_ff,
    output logic [7:0]                exc_code_ff
);

    // Sequencer states. Wide transfers spend one state per half so the
    // FIFO handshake (reads) or the write data handshake (writes) can stall either word on its own.
    typedef enum logic [2:0] {
        META_IDLE,
        META_RD_ISSUE,
        META_RD_LO,
        META_WR_HI,
        META_WR_LO,
        META_WR_ISSUE,
        META_FINISH
    } meta_state_e;

    // All engine state lives in one record: the combinational block builds
    // the next copy and a single register stage takes it, which keeps every
    // store-facing output a plain flop.
    typedef struct packed {
        meta_state_e          state;
        logic                 wide;
        logic                 is_write;
        logic [INDEX_W-1:0]   index;
        logic [COUNT_W-1:0]   left;
        logic [WORD_W-1:0]    hold;
        logic                 rd;
        logic                 wr;
        logic [PARAM_W-1:0]   wdat;
        logic                 flt;
        logic                 push;
        logic [WORD_W-1:0]    pdata;
        logic                 done;
        logic                 exc;
        logic [7:0]           exc_func;
        logic [7:0]           exc_code;
    } meta_st_s;

    meta_st_s          st_ff;
    meta_st_s          nxt_st;
    logic [1:0]        req_type;
    logic              req_wide;
    logic              req_bad;
    logic [PARAM_W-1:0] rd_val;
    logic [WORD_W-1:0] wr_msw;

    meta_word_if #(.W(WORD_W)) fifo_in ();
    meta_word_if #(.W(WORD_W)) fifo_out ();

    // ------------------------------------------------------------------
    // Request decode
    // ------------------------------------------------------------------
    // Type comes from the top address bits only, never from the index.
    assign req_type = {req_addr[TYPE_HI_BIT], req_addr[TYPE_LO_BIT]};
    assign req_wide = (req_type == TYPE_INT32) || (req_type == TYPE_FLOAT32);
    // A float request to a slave built without float, the reserved code and
    // an odd word count on a wide access all end as an addressing error.
    assign req_bad  = (req_type == TYPE_RSVD)
                    || ((req_type == TYPE_FLOAT32) && !FLOAT_OK)
                    || (req_wide && req_count[0]);

    // Widen a stored value: 16-bit parameters sign-extend for wide access.
    // Narrow reads skip this and take the low word straight from the store.
    assign rd_val = ps_is32 ? ps_rdata
                  : {{(PARAM_W-WORD_W){ps_rdata[WORD_W-1]}}, ps_rdata[WORD_W-1:0]};

    // The high word of a wide write waits here for its low word.
    assign wr_msw = st_ff.hold;

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    // The FIFO's ready stalls reads, so reply words are never dropped.
    always_comb begin
        nxt_st      = st_ff;
        // Strobes default low each cycle; the states below raise them, and a push that the FIFO has not taken stays high.
        nxt_st.rd   = 1'b0;
        nxt_st.wr   = 1'b0;
        nxt_st.push = 1'b0;
        nxt_st.done = 1'b0;
        req_ready   = 1'b0;
        wdata_ready = 1'b0;
        if (st_ff.push && !fifo_in.ready) begin
            nxt_st.push = 1'b1; // Hold the word until the FIFO takes it.
        end
        // The store takes a write in the cycle its strobe is out, so the
        // index may only move on once that strobe has been seen.
        if (st_ff.wr) begin
            nxt_st.index = st_ff.index + 14'h0001;
        end
        case (st_ff.state)
            // Accept a request; its type and refusal are decided here once.
            META_IDLE: begin
                req_ready = 1'b1;
                if (req_valid) begin
                    nxt_st.wide     = req_wide;
                    nxt_st.flt      = (req_type == TYPE_FLOAT32);
                    nxt_st.index    = req_addr[INDEX_W-1:0];
                    nxt_st.left     = req_count;
                    nxt_st.is_write = (req_func == FC_WRITE_MULTI);
                    nxt_st.exc      = 1'b0;
                    if (req_bad) begin
                        nxt_st.exc      = 1'b1;
                        nxt_st.exc_func = req_func | FC_EXC_FLAG;
                        nxt_st.exc_code = EXC_ADDR_RANGE;
                        nxt_st.state    = META_FINISH;
                    end else if (req_count == '0) begin
                        nxt_st.state = META_FINISH;
                    end else if (req_func == FC_WRITE_MULTI) begin
                        nxt_st.state = req_wide ? META_WR_HI : META_WR_LO;
                    end else begin
                        nxt_st.state = META_RD_ISSUE;
                    end
                end
            end

            // Read the current parameter; a stalled push holds the engine here.
            META_RD_ISSUE: begin
                if (!st_ff.push || fifo_in.ready) begin
                    nxt_st.rd = 1'b1;
                    nxt_st.push = 1'b1;
                    if (st_ff.wide) begin
                        nxt_st.pdata = rd_val[PARAM_W-1:WORD_W];
                        nxt_st.hold  = rd_val[WORD_W-1:0];
                        nxt_st.left  = st_ff.left - 16'h0002;
                        nxt_st.state = META_RD_LO;
                    end else begin
                        nxt_st.pdata = ps_rdata[WORD_W-1:0];
                        nxt_st.left  = st_ff.left - 16'h0001;
                        nxt_st.index = st_ff.index + 14'h0001;
                        nxt_st.state = (st_ff.left == 16'h0001) ? META_FINISH : META_RD_ISSUE;
                    end
                end
            end

            // Second half of a wide read: the low word follows the high word.
            META_RD_LO: begin
                if (fifo_in.ready) begin
                    nxt_st.push  = 1'b1;
                    nxt_st.pdata = st_ff.hold;
                    nxt_st.index = st_ff.index + 14'h0001;
                    nxt_st.state = (st_ff.left == '0) ? META_FINISH : META_RD_ISSUE;
                end
            end

            // Collect the high word of a wide write.
            META_WR_HI: begin
                wdata_ready = 1'b1;
                if (wdata_valid) begin
                    nxt_st.hold  = wdata;
                    nxt_st.state = META_WR_LO;
                end
            end

            // Collect the low word, or the only word of a narrow write.
            META_WR_LO: begin
                wdata_ready = 1'b1;
                if (wdata_valid) begin
                    nxt_st.wdat  = st_ff.wide ? {wr_msw, wdata}
                                 : {{(PARAM_W-WORD_W){wdata[WORD_W-1]}}, wdata};
                    nxt_st.state = META_WR_ISSUE;
                end
            end

            // Strobe the store; the index moves on once the strobe is out.
            META_WR_ISSUE: begin
                nxt_st.wr    = 1'b1;
                nxt_st.left  = st_ff.left - (st_ff.wide ? 16'h0002 : 16'h0001);
                if (st_ff.left == (st_ff.wide ? 16'h0002 : 16'h0001)) begin
                    nxt_st.state = META_FINISH;
                end else begin
                    nxt_st.state = st_ff.wide ? META_WR_HI : META_WR_LO;
                end
            end

            // Wait for the last reply word to enter the FIFO before done.
            META_FINISH: begin
                if (!st_ff.push || fifo_in.ready) begin
                    nxt_st.done  = 1'b1;
                    nxt_st.state = META_IDLE;
                end
            end

            // Unused encodings fall back to idle.
            default: begin
                nxt_st.state = META_IDLE;
            end
        endcase
    end

    // State register. Reset clears every strobe and flag, so the engine
    // wakes in idle with req_ready high.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ------------------------------------------------------------------
    // Store access and completion outputs
    // ------------------------------------------------------------------
    // The index output reflects the parameter being addressed now, so the
    // store's read data is valid while the issue state samples it.
    // The float flag stands for the whole block, like the access width,
    // so the store can convert every parameter of it the same way.
    assign ps_index_ff = st_ff.index;
    assign ps_rd_ff    = st_ff.rd;
    assign ps_wr_ff    = st_ff.wr;
    assign ps_wdata_ff = st_ff.wdat;
    assign ps_float_ff = st_ff.flt;
    assign done_ff     = st_ff.done;
    assign exc_ff      = st_ff.exc;
    assign exc_func_ff = st_ff.exc_func;
    assign exc_code_ff = st_ff.exc_code;

    // ------------------------------------------------------------------
    // Reply buffering
    // ------------------------------------------------------------------
    // Reply words queue in a FIFO so a slow reader never loses one; when
    // it fills, the sequencer simply waits.
    assign fifo_in.valid  = st_ff.push;
    assign fifo_in.data   = st_ff.pdata;
    assign rsp_valid      = fifo_out.valid;
    assign rsp_data       = fifo_out.data;
    assign fifo_out.ready = rsp_ready;

    // Width and depth come from the package.
    meta_fifo #(
        .W     (WORD_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .core_clk (core_clk),
        .arst_n   (arst_n),
        .wr       (fifo_in),
        .rd       (fifo_out)
    );

endmodule // meta_access

// ===== tb/meta_pstore_model.sv
// Parameter store model: eight entries, one of them wide.
// Assumes the index is taken modulo eight and reads are combinational.
`timescale 1ns/100ps
module meta_pstore_model
    import meta_pkg::*;
(
    input  wire logic               core_clk,
    input  wire logic               ps_wr_ff,
    input  wire logic [INDEX_W-1:0] ps_index_ff,
    input  wire logic [PARAM_W-1:0] ps_wdata_ff,
    output logic      [PARAM_W-1:0] ps_rdata,
    output logic                    ps_is32
);
    logic [PARAM_W-1:0] mem [8];

    // Narrow entries carry junk upper halves, so a missing extension shows.
    initial begin
        for (int k = 0; k < 8; k++) begin
            mem[k] = 32'hC3C30000 + k;
        end
        mem[7] = 32'h12345678;
        mem[0] = 32'h5A5AABCD;
        mem[1] = 32'hA5A50123;
    end

    // Entry seven is the only wide parameter.
    assign ps_is32  = (ps_index_ff[2:0] == 3'h7);
    assign ps_rdata = mem[ps_index_ff[2:0]];

    // Writes land at the edge of the strobe.
    always @(posedge core_clk) begin
        if (ps_wr_ff) begin
            mem[ps_index_ff[2:0]] <= ps_wdata_ff;
        end
    end
endmodule // meta_pstore_model

// ===== tb/meta_access_checker.sv
// Assertion checker for the extended-type access engine.
// Assumes one clock domain with an asynchronous active-low reset.
`timescale 1ns/100ps
module meta_access_checker
    import meta_pkg::*;
(
    input wire logic               core_clk,
    input wire logic               arst_n,
    input wire logic               req_valid,
    input wire logic [7:0]         req_func,
    input wire logic [ADDR_W-1:0]  req_addr,
    input wire logic [COUNT_W-1:0] req_count,
    input wire logic               req_ready,
    input wire logic               ps_rd_ff,
    input wire logic               ps_wr_ff,
    input wire logic [INDEX_W-1:0] ps_index_ff,
    input wire logic [PARAM_W-1:0] ps_wdata_ff,
    input wire logic               ps_float_ff,
    input wire logic               done_ff,
    input wire logic               exc_ff,
    input wire logic [7:0]         exc_func_ff,
    input wire logic [7:0]         exc_code_ff
);
    logic               take;
    logic [1:0]         typ_ff;
    logic [7:0]         func_ff;
    logic [INDEX_W-1:0] idx_ff;
    logic               first_ff;

    assign take = req_valid && req_ready;

    // The request is kept so later strobes can be judged against it.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            typ_ff   <= 2'h0;
            func_ff  <= 8'h00;
            idx_ff   <= '0;
            first_ff <= 1'b0;
        end else if (take) begin
            typ_ff   <= req_addr[TYPE_HI_BIT:TYPE_LO_BIT];
            func_ff  <= req_func;
            idx_ff   <= req_addr[INDEX_W-1:0];
            first_ff <= 1'b1;
        end else if (ps_wr_ff) begin
            first_ff <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);

    property p_rsvd; take && req_addr[15:14] == TYPE_RSVD |-> ##[1:3] (done_ff && exc_ff); endproperty
    a_rsvd: assert property (p_rsvd) else $error("Reserved type not refused.");
    property p_odd; take && req_addr[15:14] == TYPE_INT32 && req_count[0] |-> ##[1:3] exc_ff; endproperty
    a_odd: assert property (p_odd) else $error("Odd wide count not refused.");
    property p_nodata;
        take && (req_addr[15:14] == TYPE_RSVD || (req_addr[15:14] != TYPE_INT16 && req_count[0]))
        |=> !(ps_rd_ff || ps_wr_ff) [*4];
    endproperty
    a_nodata: assert property (p_nodata) else $error("Refused request touched store.");
    property p_code; exc_ff |-> exc_code_ff == EXC_ADDR_RANGE; endproperty
    a_code: assert property (p_code) else $error("Wrong exception code.");
    property p_func; done_ff && exc_ff |-> exc_func_ff == (func_ff | FC_EXC_FLAG); endproperty
    a_func: assert property (p_func) else $error("Wrong exception function.");
    property p_sext; ps_wr_ff && typ_ff == TYPE_INT16 |-> ps_wdata_ff[31:16] == {16{ps_wdata_ff[15]}}; endproperty
    a_sext: assert property (p_sext) else $error("Narrow write not extended.");
    property p_float; ps_rd_ff || ps_wr_ff |-> ps_float_ff == (typ_ff == TYPE_FLOAT32); endproperty
    a_float: assert property (p_float) else $error("Float flag wrong.");
    property p_index; ps_wr_ff && first_ff |-> ps_index_ff == idx_ff; endproperty
    a_index: assert property (p_index) else $error("First index wrong.");
    property p_busy; take |=> !req_ready; endproperty
    a_busy: assert property (p_busy) else $error("Ready while busy.");
endmodule // meta_access_checker

bind meta_access meta_access_checker meta_access_checker_inst (
    .core_clk, .arst_n, .req_valid, .req_func, .req_addr, .req_count, .req_ready,
    .ps_rd_ff, .ps_wr_ff, .ps_index_ff, .ps_wdata_ff, .ps_float_ff,
    .done_ff, .exc_ff, .exc_func_ff, .exc_code_ff
);

// ===== tb/meta_access_tb_top.sv
// Self-checking bench for the extended-type access engine.
// Assumes the store model and the bound checker are compiled before it.
`timescale 1ns/100ps
module meta_access_tb_top
    import meta_pkg::*;
;
    logic               core_clk, arst_n, req_valid, req_ready, wdata_valid, wdata_ready;
    logic               ps_rd_ff, ps_wr_ff, ps_float_ff, ps_is32, rsp_valid, rsp_ready;
    logic               done_ff, exc_ff;
    logic [7:0]         req_func, exc_func_ff, exc_code_ff;
    logic [ADDR_W-1:0]  req_addr;
    logic [COUNT_W-1:0] req_count;
    logic [WORD_W-1:0]  wdata, rsp_data;
    logic [INDEX_W-1:0] ps_index_ff;
    logic [PARAM_W-1:0] ps_wdata_ff, ps_rdata;
    logic [15:0]        q [$];
    logic [15:0]        wq [$];
    logic               nf_exc_ff;
    logic [7:0]         nf_exc_func_ff, nf_exc_code_ff;
    int                 bad_count, check_count;

    meta_access meta_access_inst (.core_clk, .arst_n, .req_valid, .req_func, .req_addr,
        .req_count, .req_ready, .wdata_valid, .wdata, .wdata_ready, .ps_rd_ff, .ps_wr_ff,
        .ps_index_ff, .ps_wdata_ff, .ps_float_ff, .ps_rdata, .ps_is32, .rsp_valid,
        .rsp_data, .rsp_ready, .done_ff, .exc_ff, .exc_func_ff, .exc_code_ff);
    // A second engine built without float support hears the same requests
    // and must refuse float access that the first one serves.
    meta_access #(.FLOAT_OK(1'b0)) meta_access_nf_inst (.core_clk, .arst_n, .req_valid,
        .req_func, .req_addr, .req_count, .req_ready(), .wdata_valid, .wdata,
        .wdata_ready(), .ps_rd_ff(), .ps_wr_ff(), .ps_index_ff(), .ps_wdata_ff(),
        .ps_float_ff(), .ps_rdata, .ps_is32, .rsp_valid(), .rsp_data(), .rsp_ready,
        .done_ff(), .exc_ff(nf_exc_ff), .exc_func_ff(nf_exc_func_ff),
        .exc_code_ff(nf_exc_code_ff));
    meta_pstore_model meta_pstore_model_inst (.core_clk, .ps_wr_ff, .ps_index_ff,
        .ps_wdata_ff, .ps_rdata, .ps_is32);

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: saw %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic end_sim();
        if (bad_count == 0 && check_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    // One request; reply words are gathered until done and the FIFO is dry.
    task automatic run(input logic [7:0] f, input logic [15:0] a, input logic [15:0] n,
                       input int stall);
        int t;
        bit d;
        @(posedge core_clk);
        q.delete();
        d = 1'b0;
        req_func    <= f;
        req_addr    <= a;
        req_count   <= n;
        req_valid   <= 1'b1;
        wdata_valid <= (wq.size() > 0);
        wdata       <= (wq.size() > 0) ? wq[0] : 16'h0000;
        rsp_ready   <= (stall == 0);
        for (t = 0; t < 2000 && !(d && !rsp_valid); t++) begin
            @(posedge core_clk);
            req_valid <= req_valid && !req_ready;
            if (wdata_valid && wdata_ready) begin
                void'(wq.pop_front());
            end
            if (rsp_valid && rsp_ready) begin
                q.push_back(rsp_data);
            end
            wdata_valid <= (wq.size() > 0);
            wdata       <= (wq.size() > 0) ? wq[0] : 16'h0000;
            rsp_ready   <= (t + 1 >= stall);
            d = d || done_ff;
        end
        if (t == 2000) begin
            bad_count++;
            end_sim();
        end
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_read();
        logic [15:0] e [6] = '{16'h1234, 16'h5678, 16'hFFFF, 16'hABCD, 16'h0000, 16'h0123};
        run(FC_READ_MULTI, 16'h007F, 16'h0002, 0);
        chk(q.size(), 2);
        chk(q[0], 16'h5678);
        chk(q[1], 16'hABCD);
        run(FC_READ_MULTI, 16'h407F, 16'h0006, 0);
        chk(q.size(), 6);
        for (int i = 0; i < 6; i++) begin
            chk(q[i], e[i]);
        end
        run(FC_READ_MULTI, 16'h807F, 16'h0002, 0);
        chk(q[0], 16'h1234);
        chk(exc_ff, 1'b0);
        chk(nf_exc_ff, 1'b1);
        chk(nf_exc_code_ff, EXC_ADDR_RANGE);
        chk(nf_exc_func_ff, FC_READ_MULTI | FC_EXC_FLAG);
        run(FC_RW_MULTI, 16'h007F, 16'h0000, 0);
        chk(q.size(), 0);
    endtask

    // Reserved-type and odd-wide-count refusals, each with its own function code.
    task automatic t_exc();
        logic [7:0]  f [3] = '{FC_READ_MULTI, FC_WRITE_MULTI, FC_RW_MULTI};
        logic [15:0] a [3] = '{16'h407F, 16'hC07F, 16'h807F};
        for (int i = 0; i < 3; i++) begin
            run(f[i], a[i], 16'(i + 1), 0);
            chk(exc_ff, 1'b1);
            chk(exc_code_ff, EXC_ADDR_RANGE);
            chk(exc_func_ff, f[i] | FC_EXC_FLAG);
            chk(q.size(), 0);
        end
        chk(meta_pstore_model_inst.mem[7], 32'h12345678);
    endtask

    // The reader stalls long enough for the FIFO to fill and refuse.
    task automatic t_stall();
        run(FC_READ_MULTI, 16'h0080, 16'd34, 60);
        chk(q.size(), 34);
        for (int i = 0; i < 34; i++) begin
            chk(q[i], meta_pstore_model_inst.mem[3'(i)][15:0]);
        end
    endtask

    task automatic t_write();
        wq = '{16'hABCD};
        run(FC_WRITE_MULTI, 16'h007F, 16'h0001, 0);
        chk(meta_pstore_model_inst.mem[7], 32'hFFFFABCD);
        wq = '{16'h1234};
        run(FC_WRITE_MULTI, 16'h007F, 16'h0001, 0);
        chk(meta_pstore_model_inst.mem[7], 32'h00001234);
        wq = '{16'h8765, 16'h4321};
        run(FC_WRITE_MULTI, 16'h407F, 16'h0002, 0);
        chk(meta_pstore_model_inst.mem[7], 32'h87654321);
    endtask

    // Free-running clock.
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    // Main sequence.
    initial begin
        {arst_n, req_valid, wdata_valid, rsp_ready} = 4'h0;
        req_func    = 8'h00;
        req_addr    = 16'h0000;
        req_count   = 16'h0000;
        wdata       = 16'h0000;
        bad_count   = 0;
        check_count = 0;
        repeat (4) @(posedge core_clk);
        arst_n <= 1'b1;
        t_read();
        t_exc();
        t_stall();
        t_write();
        end_sim();
    end
endmodule // meta_access_tb_top
